// *** common/dspwm_defs.svh ***
`ifndef DSPWM_DEFS_SVH
`define DSPWM_DEFS_SVH

// register byte offsets
`define DSPWM_CTRL_OFS 8'h00
`define DSPWM_COUNT_OFS 8'h04
`define DSPWM_CMPA_OFS 8'h08
`define DSPWM_CMPB_OFS 8'h0C
`define DSPWM_CAPT_OFS 8'h10
`define DSPWM_STAT_OFS 8'h14
`define DSPWM_MASK_OFS 8'h18

// reset values and writable bits
`define DSPWM_CTRL_RST 32'h0000_0000
`define DSPWM_CTRL_WMASK 32'h0000_37FF
`define DSPWM_CMP_RST 16'h0000
`define DSPWM_CAPT_RST 16'h0000
`define DSPWM_FLAG_RST 4'h0

// waveform mode encodings
`define DSPWM_MODE_CAPT_TOP 4'h8
`define DSPWM_MODE_CMPA_TOP 4'h9

// output mode encodings
`define DSPWM_OUT_OFF 2'h0
`define DSPWM_OUT_TOGGLE 2'h1
`define DSPWM_OUT_NONINV 2'h2
`define DSPWM_OUT_INV 2'h3

// prescaler select codes and terminal counts (ratio minus one)
`define DSPWM_SEL_STOP 3'h0
`define DSPWM_SEL_DIV1 3'h1
`define DSPWM_SEL_DIV8 3'h2
`define DSPWM_SEL_DIV64 3'h3
`define DSPWM_SEL_DIV256 3'h4
`define DSPWM_SEL_DIV1024 3'h5
`define DSPWM_LIM_DIV1 10'h000
`define DSPWM_LIM_DIV8 10'h007
`define DSPWM_LIM_DIV64 10'h03F
`define DSPWM_LIM_DIV256 10'h0FF
`define DSPWM_LIM_DIV1024 10'h3FF

// bus responses
`define DSPWM_RESP_OKAY 2'h0
`define DSPWM_RESP_SLVERR 2'h2

`endif

// *** common/dspwm_pkg.sv ***
package dspwm_pkg;

  // count direction of the dual-slope counter
  typedef enum logic {DSPWM_UP, DSPWM_DOWN} dspwm_dir_type;

  // control register layout, bits 13:0
  typedef struct packed {
    logic [1:0] pin_dir;    // per-channel pin direction, 1 = output
    logic rsv;
    logic [2:0] clk_sel;    // prescaler select
    logic [1:0] mode_a;     // output mode, channel a
    logic [1:0] mode_b;     // output mode, channel b
    logic [3:0] wave_mode;  // waveform mode
  } dspwm_ctrl_type;

  // status and mask register layout, bits 3:0
  typedef struct packed {
    logic capture;
    logic cmp_b;
    logic cmp_a;
    logic overflow;
  } dspwm_flags_type;

  // compare output pins, index 0 = channel a
  typedef struct packed {
    logic [1:0] oe_n;
    logic [1:0] level;
  } dspwm_pin_type;

endpackage : dspwm_pkg

// *** rtl/dspwm_timer.sv ***
// Notes on behaviour
// - dual-slope counting runs only when waveform mode is 0x8 or 0x9.
// - counter runs from zero up to TOP, then back down to zero.
// - non-inverting clears on up-count match, sets on down-count match; inverting opposite.
// - TOP is capture register in mode 0x8, compare A in 0x9.
// - counter stays at TOP for exactly one timer tick before counting down.
// - a channel's compare flag sets whenever the counter equals its compare value.
// - overflow flag sets in the tick where compare buffers load, at bottom.
// - capture or compare A flag sets at TOP when that register supplies TOP.
// - TOP must not be below any compare value, else that channel never matches.
// - compare values are double buffered and load only at bottom.
// - output mode 0x2 gives non-inverted PWM, 0x3 inverted PWM.
// - compare output reaches its pin only when the direction bit selects output.
// - tick enable comes from prescaler dividing by 1, 8, 64, 256 or 1024.
// - compare zero gives constant low, compare TOP constant high, non-inverted.
// - with compare A as TOP and toggle mode, output A toggles each match.
// - all logic on one clock; the tick is a one-cycle counter enable.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`include "dspwm_defs.svh"

module dspwm_timer #(
  parameter int W = 16  // counter width
) (
  input wire logic i_core_clk,                 // core clock
  input wire logic i_resetn,                   // synchronous reset, active low
  input wire logic [7:0] i_awaddr,             // write address
  input wire logic i_awvalid,                  // write address valid
  output logic o_awready,                      // write address ready
  input wire logic [31:0] i_wdata,             // write data
  input wire logic [3:0] i_wstrb,              // write byte strobes
  input wire logic i_wvalid,                   // write data valid
  output logic o_wready,                       // write data ready
  output logic [1:0] o_bresp,                  // write response
  output logic o_bvalid,                       // write response valid
  input wire logic i_bready,                   // write response ready
  input wire logic [7:0] i_araddr,             // read address
  input wire logic i_arvalid,                  // read address valid
  output logic o_arready,                      // read address ready
  output logic [31:0] o_rdata,                 // read data
  output logic [1:0] o_rresp,                  // read response
  output logic o_rvalid,                       // read data valid
  input wire logic i_rready,                   // read data ready
  output dspwm_pkg::dspwm_pin_type o_pin,      // compare output pins
  output logic o_irq                           // interrupt, active high level
);
  import dspwm_pkg::*;

  logic [31:0] ctrl_reg;
  dspwm_ctrl_type ctrl;
  logic [W-1:0] cmp_buf [2];
  logic [W-1:0] cmp_act [2];
  logic [W-1:0] capt_reg;
  dspwm_flags_type status;
  dspwm_flags_type mask;
  dspwm_flags_type next_status;
  dspwm_flags_type set_flags;
  dspwm_flags_type clr_flags;
  logic [W-1:0] cnt;
  logic [W-1:0] top;
  dspwm_dir_type dir;
  logic [9:0] pre_cnt;
  logic [9:0] pre_lim;
  logic tick;
  logic pfc_mode;
  logic run;
  logic at_bottom;
  logic at_top;
  logic eff_up;
  logic [1:0] match;
  logic [1:0] out_lvl;
  logic [1:0] next_lvl;
  logic [1:0] mode [2];
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_hit;

  // byte-lane merge of a bus write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  assign ctrl = dspwm_ctrl_type'(ctrl_reg[13:0]);
  assign mode[0] = ctrl.mode_a;
  assign mode[1] = ctrl.mode_b;

  ////////////////////////////////////////////////////////////////////////////////
  // register bus

  // write channel: address and data taken in either order, answer after both
  assign do_write = !o_awready && !o_wready && !o_bvalid;

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `DSPWM_RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        o_awready <= 1'b0;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        o_wready <= 1'b0;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp <= wr_hit ? `DSPWM_RESP_OKAY : `DSPWM_RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // address decode for writes; the count register is read-only but accepted
  always_comb begin
    unique case (aw_addr)
      `DSPWM_CTRL_OFS, `DSPWM_COUNT_OFS, `DSPWM_CMPA_OFS, `DSPWM_CMPB_OFS,
      `DSPWM_CAPT_OFS, `DSPWM_STAT_OFS, `DSPWM_MASK_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // software-written registers; compare writes land in the buffers only
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ctrl_reg <= `DSPWM_CTRL_RST;
      cmp_buf[0] <= `DSPWM_CMP_RST;
      cmp_buf[1] <= `DSPWM_CMP_RST;
      capt_reg <= `DSPWM_CAPT_RST;
      mask <= `DSPWM_FLAG_RST;
    end else if (do_write) begin
      unique case (aw_addr)
        `DSPWM_CTRL_OFS: ctrl_reg <= merge(ctrl_reg, w_data, w_strb) & `DSPWM_CTRL_WMASK;
        `DSPWM_CMPA_OFS: cmp_buf[0] <= W'(merge(32'(cmp_buf[0]), w_data, w_strb));
        `DSPWM_CMPB_OFS: cmp_buf[1] <= W'(merge(32'(cmp_buf[1]), w_data, w_strb));
        `DSPWM_CAPT_OFS: capt_reg <= W'(merge(32'(capt_reg), w_data, w_strb));
        `DSPWM_MASK_OFS: mask <= dspwm_flags_type'(w_strb[0] ? w_data[3:0] : mask);
        default: ;
      endcase
    end
  end

  // read channel: one read at a time, data one cycle after the address
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `DSPWM_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= `DSPWM_RESP_OKAY;
      unique case (i_araddr)
        `DSPWM_CTRL_OFS: o_rdata <= ctrl_reg;
        `DSPWM_COUNT_OFS: o_rdata <= 32'(cnt);
        `DSPWM_CMPA_OFS: o_rdata <= 32'(cmp_buf[0]);
        `DSPWM_CMPB_OFS: o_rdata <= 32'(cmp_buf[1]);
        `DSPWM_CAPT_OFS: o_rdata <= 32'(capt_reg);
        `DSPWM_STAT_OFS: o_rdata <= {28'h000_0000, status};
        `DSPWM_MASK_OFS: o_rdata <= {28'h000_0000, mask};
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= `DSPWM_RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // prescaler: the tick is an enable, never a clock, so no second domain exists

  always_comb begin
    unique case (ctrl.clk_sel)
      `DSPWM_SEL_DIV1: pre_lim = `DSPWM_LIM_DIV1;
      `DSPWM_SEL_DIV8: pre_lim = `DSPWM_LIM_DIV8;
      `DSPWM_SEL_DIV64: pre_lim = `DSPWM_LIM_DIV64;
      `DSPWM_SEL_DIV256: pre_lim = `DSPWM_LIM_DIV256;
      default: pre_lim = `DSPWM_LIM_DIV1024;
    endcase
  end

  // select codes above the last ratio stop the timer like code zero
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      pre_cnt <= 10'h000;
      tick <= 1'b0;
    end else if (ctrl.clk_sel == `DSPWM_SEL_STOP || ctrl.clk_sel > `DSPWM_SEL_DIV1024) begin
      pre_cnt <= 10'h000;
      tick <= 1'b0;
    end else if (pre_cnt >= pre_lim) begin
      pre_cnt <= 10'h000;
      tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 10'h001;
      tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // dual-slope counter

  assign pfc_mode = (ctrl.wave_mode == `DSPWM_MODE_CAPT_TOP) ||
                    (ctrl.wave_mode == `DSPWM_MODE_CMPA_TOP);
  assign run = tick && pfc_mode;
  // software keeps top at 3 or more; a smaller top still reverses safely
  assign top = (ctrl.wave_mode == `DSPWM_MODE_CMPA_TOP) ? cmp_act[0] : capt_reg;
  assign at_bottom = run && cnt == '0;
  assign at_top = run && cnt >= top;
  // bottom counts as rising and top as falling, so the extremes give flat levels
  assign eff_up = (cnt == '0) || (dir == DSPWM_UP && cnt < top);

  // reverse at or past top, never at zero: a stale top of zero would wrap the count
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      cnt <= '0;
      dir <= DSPWM_UP;
    end else if (run) begin
      unique case (dir)
        DSPWM_UP: begin
          if (cnt >= top && cnt != '0) begin
            dir <= DSPWM_DOWN;
            cnt <= cnt - W'(1);
          end else begin
            cnt <= cnt + W'(1);
          end
        end
        DSPWM_DOWN: begin
          if (cnt == '0) begin
            dir <= DSPWM_UP;
            cnt <= cnt + W'(1);
          end else begin
            cnt <= cnt - W'(1);
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare channels

  // per-channel match and next output level
  for (genvar i = 0; i < 2; i++) begin : g_chan
    assign match[i] = run && cnt == cmp_act[i];
    always_comb begin
      next_lvl[i] = out_lvl[i];
      if (match[i]) begin
        unique case (mode[i])
          `DSPWM_OUT_NONINV: next_lvl[i] = !eff_up;
          `DSPWM_OUT_INV: next_lvl[i] = eff_up;
          `DSPWM_OUT_TOGGLE: begin
            if (i == 0 && ctrl.wave_mode == `DSPWM_MODE_CMPA_TOP) begin
              next_lvl[i] = !out_lvl[i];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // active compare values load only at bottom, so both slopes stay equal
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      cmp_act[0] <= `DSPWM_CMP_RST;
      cmp_act[1] <= `DSPWM_CMP_RST;
    end else if (at_bottom) begin
      cmp_act[0] <= cmp_buf[0];
      cmp_act[1] <= cmp_buf[1];
    end
  end

  // output levels and pins; a channel in mode zero leaves its pin undriven
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      out_lvl <= 2'h0;
      o_pin <= '{oe_n: 2'h3, level: 2'h0};
    end else begin
      out_lvl <= next_lvl;
      for (int i = 0; i < 2; i++) begin
        o_pin.level[i] <= next_lvl[i];
        o_pin.oe_n[i] <= !(ctrl.pin_dir[i] && mode[i] != `DSPWM_OUT_OFF);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flags and interrupt

  assign set_flags.overflow = at_bottom;
  assign set_flags.cmp_a = match[0];
  assign set_flags.cmp_b = match[1];
  assign set_flags.capture = at_top && ctrl.wave_mode == `DSPWM_MODE_CAPT_TOP;
  assign clr_flags = (do_write && aw_addr == `DSPWM_STAT_OFS && w_strb[0]) ?
                     dspwm_flags_type'(w_data[3:0]) : `DSPWM_FLAG_RST;
  // a new event wins over a clear in the same cycle
  assign next_status = (status & ~clr_flags) | set_flags;

  // flags register the tick cycle's events, so they show one edge later
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      status <= `DSPWM_FLAG_RST;
      o_irq <= 1'b0;
    end else begin
      status <= next_status;
      o_irq <= |(next_status & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_at_top;
    run && dir == DSPWM_UP && cnt == top && top != '0;
  endsequence
  sequence s_leave_top;
    dir == DSPWM_DOWN && cnt == $past(cnt) - W'(1);
  endsequence

  a_mode_gate: assert property (!pfc_mode |=> $stable(cnt))
    else $error("counter moved outside dual-slope mode");
  a_count_up: assert property (run && dir == DSPWM_UP && cnt < top |=> cnt == $past(cnt) + W'(1))
    else $error("up count did not step by one");
  a_clear_up: assert property (match[0] && mode[0] == `DSPWM_OUT_NONINV && eff_up |=> !out_lvl[0])
    else $error("non-inverted output not cleared on rising match");
  a_top_source: assert property (ctrl.wave_mode == `DSPWM_MODE_CAPT_TOP |-> top == capt_reg)
    else $error("top not taken from capture register");
  a_top_hold: assert property (s_at_top |=> s_leave_top)
    else $error("counter did not turn after one tick at top");
  a_flag_next: assert property (match[1] |=> status.cmp_b)
    else $error("compare b flag not set after match");
  a_ovf_load: assert property (at_bottom |=> status.overflow && cmp_act[1] == $past(cmp_buf[1]))
    else $error("overflow flag and buffer load not together");
  a_cmp_hold: assert property (!at_bottom |=> $stable(cmp_act[1]))
    else $error("active compare changed away from bottom");
  a_pin_gate: assert property (!ctrl.pin_dir[0] |=> o_pin.oe_n[0])
    else $error("pin driven while direction is input");
  a_tick_div8: assert property (tick && ctrl.clk_sel == `DSPWM_SEL_DIV8 |=> !tick [*7])
    else $error("prescaler ticked early at divide by eight");
  a_capt_flag: assert property (at_top && ctrl.wave_mode == `DSPWM_MODE_CAPT_TOP |=> status.capture)
    else $error("capture flag not set at top");

endmodule : dspwm_timer

// *** testbench/dspwm_load.sv ***
module dspwm_load
  import dspwm_pkg::*;
(
  input wire logic i_clk,           // core clock
  input wire dspwm_pin_type i_pin,  // compare pins of the timer
  input wire logic i_start,         // start a measuring window
  input wire logic [15:0] i_win,    // window length in clocks
  output logic o_done,              // window finished, one cycle
  output logic [31:0] o_high        // high clocks seen, {a, b}
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] lvl;
  logic [15:0] left;
  logic [15:0] hi_a;
  logic [15:0] hi_b;
  ////////////////////////////////////////////////////////////////////////////////
  // a released pin is pulled low by the load resistor, so it never keeps a level
  assign lvl = ~i_pin.oe_n & i_pin.level;
  initial begin
    o_done = 1'b0;
    o_high = 32'h0;
    left = 16'h0;
    hi_a = 16'h0;
    hi_b = 16'h0;
  end
  // count high clocks; a window of whole periods makes the phase irrelevant
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_start) begin
      left <= i_win;
      hi_a <= 16'h0;
      hi_b <= 16'h0;
    end else if (left != 16'h0) begin
      left <= left - 16'h1;
      hi_a <= hi_a + {15'h0, lvl[0]};
      hi_b <= hi_b + {15'h0, lvl[1]};
      if (left == 16'h1) begin
        o_done <= 1'b1;
        o_high <= {hi_a + {15'h0, lvl[0]}, hi_b + {15'h0, lvl[1]}};
      end
    end
  end
endmodule : dspwm_load

// *** testbench/dspwm_timer_tb.sv ***
`include "dspwm_defs.svh"
`define DSPWM_CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module dspwm_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dspwm_pkg::*;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, start, done;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, high, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] win, rb;
  logic [33:0] exp_v;
  dspwm_pin_type pin;
  int fails, n_checks, k;
  integer seed;
  logic [33:0] q[$];
  ////////////////////////////////////////////////////////////////////////////////
  dspwm_timer dspwm_timer_i (.i_core_clk(clk), .i_resetn(rstn), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_pin(pin), .o_irq(irq));
  dspwm_load dspwm_load_i (.i_clk(clk), .i_pin(pin), .i_start(start), .i_win(win),
    .o_done(done), .o_high(high));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // watcher: every answer takes the oldest note off the queue
  always @(posedge clk) begin
    if (bvalid && bready) begin
      exp_v = q.pop_front();
      `DSPWM_CHK({bresp, 32'h0}, exp_v)
    end
    if (rvalid && rready) begin
      exp_v = q.pop_front();
      `DSPWM_CHK({rresp, rdata}, exp_v)
    end
    if (done) begin
      exp_v = q.pop_front();
      `DSPWM_CHK({2'h0, high}, exp_v)
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic limit(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      $display("ERROR %0t wait ran out", $time);
      test_done();
    end
  endtask : limit
  // each channel is released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ad, wd, bs;
    q.push_back({er, 32'h0});
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    bs = 1'b0;
    for (n = 0; n < 200 && !bs; n++) begin
      @(posedge clk);
      if (awvalid && awready) ad = 1'b1;
      if (wvalid && wready) wd = 1'b1;
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
      bs = bvalid;
    end
    bready <= 1'b0;
    limit(n, 200);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    logic rs;
    q.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rs = 1'b0;
    for (n = 0; n < 200 && !rs; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      rs = rvalid;
    end
    rready <= 1'b0;
    limit(n, 200);
  endtask : rd
  function automatic logic [31:0] ctl(input logic [3:0] wm, input logic [2:0] sel,
                                      input logic [1:0] ma, mb, dir);
    return {18'h0, dir, 1'b0, sel, ma, mb, wm};
  endfunction : ctl
  // high clocks per period of a pwm channel with compare c, ratio n
  function automatic logic [15:0] hi_of(input logic [1:0] m, input logic [15:0] c, t, n);
    if (m == `DSPWM_OUT_NONINV) return 16'(2 * c * n);
    if (m == `DSPWM_OUT_INV) return 16'(2 * (t - c) * n);
    return 16'h0;
  endfunction : hi_of
  // stop, load registers, start, let it settle, then measure two periods
  task automatic run(input logic [3:0] wm, input logic [2:0] sel, input logic [15:0] top,
                     input logic [15:0] ca, cb, input logic [1:0] ma, mb, dir,
                     input int per, input logic [15:0] ea, eb);
    int n;
    wr(`DSPWM_CTRL_OFS, 32'h0, `DSPWM_RESP_OKAY);
    wr(`DSPWM_CAPT_OFS, {16'h0, top}, `DSPWM_RESP_OKAY);
    wr(`DSPWM_CMPA_OFS, {16'h0, ca}, `DSPWM_RESP_OKAY);
    wr(`DSPWM_CMPB_OFS, {16'h0, cb}, `DSPWM_RESP_OKAY);
    wr(`DSPWM_CTRL_OFS, ctl(wm, sel, ma, mb, dir), `DSPWM_RESP_OKAY);
    repeat (4 * per) @(posedge clk);
    q.push_back({2'h0, 16'(2 * ea), 16'(2 * eb)});
    win <= 16'(2 * per);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (n = 0; n < 2 * per + 20 && !done; n++) @(posedge clk);
    limit(n, 2 * per + 20);
    @(posedge clk);
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, start} = 6'h0;
    {awaddr, araddr, wdata, wstrb, win} = 68'h0;
    fails = 0;
    n_checks = 0;
    seed = 32'hb0a94040;
    rstn = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(`DSPWM_CTRL_OFS, {`DSPWM_RESP_OKAY, 32'h0});
    rd(`DSPWM_CMPA_OFS, {`DSPWM_RESP_OKAY, 32'h0});
    rd(`DSPWM_STAT_OFS, {`DSPWM_RESP_OKAY, 32'h0});
    rd(`DSPWM_COUNT_OFS, {`DSPWM_RESP_OKAY, 32'h0});
    rd(8'h1C, {`DSPWM_RESP_SLVERR, 32'h0});
    wr(8'h20, 32'h5, `DSPWM_RESP_SLVERR);
    // random control with the wave mode kept off: a live tick must not move the count
    v = $random(seed) & 32'hFFFF_FFF0;
    wr(`DSPWM_CTRL_OFS, v, `DSPWM_RESP_OKAY);
    rd(`DSPWM_CTRL_OFS, {`DSPWM_RESP_OKAY, v & `DSPWM_CTRL_WMASK});
    rd(`DSPWM_COUNT_OFS, {`DSPWM_RESP_OKAY, 32'h0});
    rb = 16'h1 + 16'($unsigned($random(seed)) % 4);
    // tops stay at 3 or more and never below a compare value
    run(`DSPWM_MODE_CAPT_TOP, `DSPWM_SEL_DIV1, 16'h5, 16'h3, rb, `DSPWM_OUT_INV,
        `DSPWM_OUT_NONINV, 2'h3, 10, hi_of(2'h3, 16'h3, 16'h5, 16'h1),
        hi_of(2'h2, rb, 16'h5, 16'h1));
    // flags while the timer runs, first with nothing unmasked, then with overflow unmasked
    wr(`DSPWM_MASK_OFS, 32'h0, `DSPWM_RESP_OKAY);
    wr(`DSPWM_STAT_OFS, 32'hF, `DSPWM_RESP_OKAY);
    repeat (20) @(posedge clk);
    `DSPWM_CHK(irq, 1'b0)
    rd(`DSPWM_STAT_OFS, {`DSPWM_RESP_OKAY, 32'hF});
    wr(`DSPWM_MASK_OFS, 32'h1, `DSPWM_RESP_OKAY);
    for (k = 0; k < 20 && !irq; k++) @(posedge clk);
    `DSPWM_CHK(irq, 1'b1)
    wr(`DSPWM_CTRL_OFS, 32'h0, `DSPWM_RESP_OKAY);
    wr(`DSPWM_STAT_OFS, 32'hF, `DSPWM_RESP_OKAY);
    rd(`DSPWM_STAT_OFS, {`DSPWM_RESP_OKAY, 32'h0});
    `DSPWM_CHK(irq, 1'b0)
    run(`DSPWM_MODE_CAPT_TOP, `DSPWM_SEL_DIV8, 16'h5, 16'h3, 16'h2, `DSPWM_OUT_INV,
        `DSPWM_OUT_NONINV, 2'h3, 80, 16'd32, 16'd32);
    run(`DSPWM_MODE_CAPT_TOP, `DSPWM_SEL_DIV1, 16'h5, 16'h0, 16'h5, `DSPWM_OUT_NONINV,
        `DSPWM_OUT_NONINV, 2'h3, 10, 16'd0, 16'd10);
    run(`DSPWM_MODE_CAPT_TOP, `DSPWM_SEL_DIV1, 16'h5, 16'h0, 16'h5, `DSPWM_OUT_INV,
        `DSPWM_OUT_INV, 2'h3, 10, 16'd10, 16'd0);
    // compare a is top: a toggles once a period, b is released from its pin
    run(`DSPWM_MODE_CMPA_TOP, `DSPWM_SEL_DIV1, 16'h9, 16'h4, 16'h1, `DSPWM_OUT_TOGGLE,
        `DSPWM_OUT_NONINV, 2'h1, 8, 16'd4, 16'd0);
    test_done();
  end
endmodule : dspwm_timer_tb
